// ---- hw/sbrx_defines.svh ----
// Register offsets, field positions, reset values and timing constants.
`ifndef SBRX_DEFINES_SVH
`define SBRX_DEFINES_SVH

// CPU-side register byte addresses
`define SBRX_ADDR_W 16
`define SBRX_ADDR_CMD 16'hf8f0
`define SBRX_ADDR_UAR_LOW 16'hf8f1
`define SBRX_ADDR_UAR_HIGH 16'hf8f2
`define SBRX_ADDR_RBF 16'hf8f4
`define SBRX_ADDR_MCNT 16'hf8f5
`define SBRX_ADDR_SCNT 16'hf8f6
`define SBRX_ADDR_RC 16'hf8f8
`define SBRX_ADDR_SRC_LOW 16'hf8f9
`define SBRX_ADDR_SRC_HIGH 16'hf8fa

// Reset values
`define SBRX_RC_TX_RESET 3'h4
`define SBRX_REC_RESET 4'hf
`define SBRX_CNT_RESET 8'h00
`define SBRX_REG_RESET 8'h00
`define SBRX_READ_ZERO 8'h00

// Command register fields
`define SBRX_CMD_SOFT_RESET_REQUEST_BIT 0
`define SBRX_CMD_OPTION_ERROR_REPORT_ENABLE_BIT 1

// Own address low / conditions register fields
`define SBRX_UAR_ADDR_MSB 7
`define SBRX_UAR_ADDR_LSB 4
`define SBRX_UAR_SLTX_BIT 2
`define SBRX_UAR_MODE_MSB 1
`define SBRX_UAR_MODE_LSB 0

// Reception code encodings: {kind, event}
`define SBRX_KIND_BITS_MASTER 2'h0
`define SBRX_KIND_BITS_SLAVE 2'h1
`define SBRX_KIND_BITS_MULTI 2'h2
`define SBRX_EV_BITS_START 2'h0
`define SBRX_EV_BITS_FULL 2'h1
`define SBRX_EV_BITS_DONE 2'h2
`define SBRX_EV_BITS_ABORT 2'h3
`define SBRX_REC_MCAST_ERR 4'hc

// Index of the last frame header byte; header is 3 bytes
`define SBRX_HDR_LAST 2'h2

// Timing: buffer-read limits in microseconds, clock in MHz
`define SBRX_CLK_MHZ 250
`define SBRX_LIMIT_M0_US 1570
`define SBRX_LIMIT_M1_US 390
`define SBRX_LIMIT_M2_US 280
`define SBRX_LIMIT_W 20

// Receive buffer geometry
`define SBRX_FIFO_DEPTH 16
`define SBRX_BYTE_W 8

`endif

// ---- hw/sbrx_pkg.sv ----
// Types shared by the reception status block.
package sbrx_pkg;
`include "sbrx_defines.svh"

    typedef enum logic [1:0] {
        SBRX_KIND_MASTER,
        SBRX_KIND_SLAVE,
        SBRX_KIND_MULTI
    } sbrx_kind_e;

    typedef enum logic [1:0] {
        SBRX_ST_IDLE,
        SBRX_ST_HEADER,
        SBRX_ST_DATA
    } sbrx_state_e;

    typedef logic [3:0] sbrx_code_t;

    // Kind field of a reception code
    function automatic logic [1:0] sbrx_kind_bits(input sbrx_kind_e k);
        case (k)
            SBRX_KIND_MASTER: sbrx_kind_bits = `SBRX_KIND_BITS_MASTER;
            SBRX_KIND_SLAVE: sbrx_kind_bits = `SBRX_KIND_BITS_SLAVE;
            SBRX_KIND_MULTI: sbrx_kind_bits = `SBRX_KIND_BITS_MULTI;
            default: sbrx_kind_bits = `SBRX_KIND_BITS_MASTER;
        endcase
    endfunction : sbrx_kind_bits
endpackage : sbrx_pkg

// ---- hw/sbrx_fifo.sv ----
// Receive buffer FIFO with valid/ready on both sides.
`timescale 1ns/1ns
module sbrx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    localparam int AW = $clog2(DEPTH)
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in,
    output logic [AW:0] count_out
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Handshakes; full and empty come from the fill count
    assign in_ready_out = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];
    assign count_out = count;
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Storage has no reset; only the pointers matter
    always_ff @(posedge clock_in)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // Write pointer, wraps for any depth
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in || flush_in)
            wr_ptr <= '0;
        else if (push)
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end

    // Read pointer
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in || flush_in)
            rd_ptr <= '0;
        else if (pop)
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end

    // Fill count
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in || flush_in)
            count <= '0;
        else if (push && !pop)
            count <= count + 1'b1;
        else if (pop && !push)
            count <= count - 1'b1;
    end
endmodule : sbrx_fifo

// ---- hw/sbrx_limit_timer.sv ----
// One-shot timer that flags a missed buffer read.
`timescale 1ns/1ns
module sbrx_limit_timer #(
    parameter int W = 20
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic arm_in,
    input wire logic disarm_in,
    input wire logic [W-1:0] limit_in,
    output logic expired_out
);
    logic running;
    logic [W-1:0] cnt;
    logic hit;

    // Limit is counted in whole cycles from the arming edge
    assign hit = running && (cnt + 1'b1 >= limit_in);

    // Run flag; disarm beats a late expiry
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in || disarm_in)
            running <= 1'b0;
        else if (arm_in)
            running <= 1'b1;
        else if (hit)
            running <= 1'b0;
    end

    // Cycle counter
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in || arm_in)
            cnt <= '0;
        else if (running)
            cnt <= cnt + 1'b1;
    end

    // One-cycle expiry pulse
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in || disarm_in || arm_in)
            expired_out <= 1'b0;
        else
            expired_out <= hit;
    end
endmodule : sbrx_limit_timer

// ---- hw/sbrx_rx_status.sv ----
// Reception return codes, receive buffer and own address registers.
`timescale 1ns/1ns
`include "sbrx_defines.svh"

// Overview of operation
// - Master start: code 0000, header in buffer
// - Master buffer full: code 0001, NAK late
// - Master complete: code 0010, count in register
// - Master aborted: code 0011, partial data kept
// - Slave start: code 0100, header in buffer
// - Slave buffer full: code 0101, NAK late
// - Slave complete: code 0110, slave count kept
// - Slave aborted: code 0111, partial data kept
// - Multicast start: code 1000, header in buffer
// - Multicast buffer full: code 1001, NAK late
// - Multicast complete: code 1010, slave count kept
// - Multicast aborted: code 1011, partial data kept
// - Multicast error: code 1100, capture source address
// - Error code only with report enable set
// - Own address: high register plus low nibble
// - Mode and slave transmit from low register
// - Address registers written bytewise, cleared on any reset
// - Byte counts readable, cleared on any reset
// - Return code reads 4fh after any reset
module sbrx_rx_status #(
    parameter int FIFO_DEPTH = `SBRX_FIFO_DEPTH,
    parameter int unsigned LIMIT_M0_CYC =
        `SBRX_LIMIT_M0_US * `SBRX_CLK_MHZ,
    parameter int unsigned LIMIT_M1_CYC =
        `SBRX_LIMIT_M1_US * `SBRX_CLK_MHZ,
    parameter int unsigned LIMIT_M2_CYC =
        `SBRX_LIMIT_M2_US * `SBRX_CLK_MHZ,
    localparam int AW = $clog2(FIFO_DEPTH)
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [`SBRX_ADDR_W-1:0] cpu_addr_in,
    input wire logic cpu_wr_in,
    input wire logic cpu_rd_in,
    input wire logic [7:0] cpu_wdata_in,
    output logic [7:0] cpu_rdata_out,
    input wire logic link_start_in,
    input wire sbrx_pkg::sbrx_kind_e link_kind_in,
    input wire logic link_byte_valid_in,
    input wire logic [7:0] link_byte_in,
    output logic link_byte_ready_out,
    input wire logic link_end_in,
    input wire logic link_complete_in,
    input wire logic link_mcast_err_in,
    input wire logic [11:0] link_mcast_src_in,
    output logic link_nak_out,
    output logic [11:0] own_addr_out,
    output logic [1:0] tx_mode_out,
    output logic slave_tx_enable_out,
    output logic rc_changed_out
);
    import sbrx_pkg::*;

    logic sw_reset;
    logic clr;
    logic wr_cmd;
    logic wr_uar_low;
    logic wr_uar_high;
    logic rd_rbf;
    logic report_en;
    logic [7:0] uar_low;
    logic [7:0] uar_high;
    sbrx_state_e st;
    sbrx_state_e next_st;
    sbrx_kind_e kind;
    logic [1:0] hdr_cnt;
    logic [7:0] byte_cnt;
    logic [7:0] next_byte_cnt;
    logic nak;
    logic next_nak;
    logic [3:0] rec;
    logic rc_set;
    sbrx_code_t rc_val;
    logic [7:0] master_cnt;
    logic [7:0] slave_cnt;
    logic [7:0] src_low;
    logic [7:0] src_high;
    logic push;
    logic pop;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic [AW:0] fill;
    logic [AW:0] next_fill;
    logic full_hit;
    logic mcast_err;
    logic expired;
    logic [`SBRX_LIMIT_W-1:0] limit;

    // Register strobes; a soft reset clears at the next edge
    assign sw_reset = cpu_wr_in && (cpu_addr_in == `SBRX_ADDR_CMD)
        && cpu_wdata_in[`SBRX_CMD_SOFT_RESET_REQUEST_BIT];
    assign clr = !rst_b_in || sw_reset;
    assign wr_cmd = cpu_wr_in && (cpu_addr_in == `SBRX_ADDR_CMD);
    assign wr_uar_low = cpu_wr_in && (cpu_addr_in == `SBRX_ADDR_UAR_LOW);
    assign wr_uar_high = cpu_wr_in && (cpu_addr_in == `SBRX_ADDR_UAR_HIGH);
    assign rd_rbf = cpu_rd_in && (cpu_addr_in == `SBRX_ADDR_RBF);

    // Bytes enter only while a frame is open and ready was shown; reads pop at any time
    assign push = link_byte_valid_in && link_byte_ready_out
        && fifo_in_ready && (st != SBRX_ST_IDLE);
    assign pop = rd_rbf && fifo_out_valid;
    assign mcast_err = link_mcast_err_in && report_en;

    // Fill level after this edge, used to keep ready registered
    always_comb
    begin
        next_fill = fill;
        if (push && !pop)
            next_fill = fill + 1'b1;
        else if (pop && !push)
            next_fill = fill - 1'b1;
    end

    // Buffer just became full during an open frame
    assign full_hit = (st != SBRX_ST_IDLE)
        && (next_fill == (AW+1)'(FIFO_DEPTH))
        && (fill != (AW+1)'(FIFO_DEPTH));

    // Software reset bit self-clears; report enable reloads on every command write
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
            report_en <= 1'b0;
        else if (wr_cmd)
            report_en <= cpu_wdata_in[`SBRX_CMD_OPTION_ERROR_REPORT_ENABLE_BIT];
    end

    // Own address registers: plain byte writes
    always_ff @(posedge clock_in)
    begin
        if (clr)
        begin
            uar_low <= `SBRX_REG_RESET;
            uar_high <= `SBRX_REG_RESET;
        end
        else
        begin
            if (wr_uar_low)
                uar_low <= cpu_wdata_in;
            if (wr_uar_high)
                uar_high <= cpu_wdata_in;
        end
    end

    // Address and conditions straight from the registers
    assign own_addr_out = {uar_high,
        uar_low[`SBRX_UAR_ADDR_MSB:`SBRX_UAR_ADDR_LSB]};
    assign tx_mode_out =
        uar_low[`SBRX_UAR_MODE_MSB:`SBRX_UAR_MODE_LSB];
    assign slave_tx_enable_out = uar_low[`SBRX_UAR_SLTX_BIT];

    // Frame sequencing: header bytes first, then data
    always_comb
    begin
        next_st = st;
        case (st)
            SBRX_ST_IDLE:
                if (link_start_in)
                    next_st = SBRX_ST_HEADER;
            SBRX_ST_HEADER:
                if (link_start_in)
                    next_st = SBRX_ST_HEADER;
                else if (link_end_in || mcast_err)
                    next_st = SBRX_ST_IDLE;
                else if (push && hdr_cnt == `SBRX_HDR_LAST)
                    next_st = SBRX_ST_DATA;
            SBRX_ST_DATA:
                if (link_start_in)
                    next_st = SBRX_ST_HEADER;
                else if (link_end_in || mcast_err)
                    next_st = SBRX_ST_IDLE;
            default:
                next_st = SBRX_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (clr)
            st <= SBRX_ST_IDLE;
        else
            st <= next_st;
    end

    // Frame kind and header position
    always_ff @(posedge clock_in)
    begin
        if (clr)
        begin
            kind <= SBRX_KIND_MASTER;
            hdr_cnt <= 2'h0;
        end
        else if (link_start_in)
        begin
            kind <= link_kind_in;
            hdr_cnt <= 2'h0;
        end
        else if (push && st == SBRX_ST_HEADER)
            hdr_cnt <= hdr_cnt + 2'h1;
    end

    // Data byte count, header excluded, saturating
    always_comb
    begin
        next_byte_cnt = byte_cnt;
        if (push && st == SBRX_ST_DATA && byte_cnt != 8'hff)
            next_byte_cnt = byte_cnt + 8'h01;
    end

    always_ff @(posedge clock_in)
    begin
        if (clr || link_start_in)
            byte_cnt <= `SBRX_CNT_RESET;
        else
            byte_cnt <= next_byte_cnt;
    end

    // Missed-read limit chosen by transmission mode
    always_comb
    begin
        case (tx_mode_out)
            2'h0: limit = `SBRX_LIMIT_W'(LIMIT_M0_CYC);
            2'h1: limit = `SBRX_LIMIT_W'(LIMIT_M1_CYC);
            default: limit = `SBRX_LIMIT_W'(LIMIT_M2_CYC);
        endcase
    end

    // A read of the buffer stops the countdown
    sbrx_limit_timer #(
        .W(`SBRX_LIMIT_W)
    ) u_timer (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .arm_in(full_hit),
        .disarm_in(clr || pop || link_start_in || link_end_in),
        .limit_in(limit),
        .expired_out(expired)
    );

    // Refusal holds to the end of the frame once the read is late
    always_comb
    begin
        next_nak = nak;
        if (clr || link_start_in || link_end_in || mcast_err)
            next_nak = 1'b0;
        else if (expired)
            next_nak = 1'b1;
    end

    always_ff @(posedge clock_in)
    begin
        if (clr)
            nak <= 1'b0;
        else
            nak <= next_nak;
    end

    // Registered ready sees the fill level of the next cycle
    always_ff @(posedge clock_in)
    begin
        if (clr)
        begin
            link_byte_ready_out <= 1'b0;
            link_nak_out <= 1'b0;
        end
        else
        begin
            link_byte_ready_out <= (next_st != SBRX_ST_IDLE) && !next_nak
                && (next_fill < (AW+1)'(FIFO_DEPTH));
            link_nak_out <= next_nak;
        end
    end

    // Receive buffer; header and data share it
    sbrx_fifo #(
        .WIDTH(`SBRX_BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .flush_in(sw_reset),
        .in_valid_in(push),
        .in_data_in(link_byte_in),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(rd_rbf),
        .count_out(fill)
    );

    // Code selection; error beats end, end beats full, full beats start
    always_comb
    begin
        rc_set = 1'b1;
        rc_val = `SBRX_REC_RESET;
        if (mcast_err)
            rc_val = `SBRX_REC_MCAST_ERR;
        else if (link_end_in && st != SBRX_ST_IDLE && link_complete_in)
            rc_val = {sbrx_kind_bits(kind),
                `SBRX_EV_BITS_DONE};
        else if (link_end_in && st != SBRX_ST_IDLE)
            rc_val = {sbrx_kind_bits(kind),
                `SBRX_EV_BITS_ABORT};
        else if (full_hit)
            rc_val = {sbrx_kind_bits(kind),
                `SBRX_EV_BITS_FULL};
        else if (link_start_in)
            rc_val = {sbrx_kind_bits(link_kind_in),
                `SBRX_EV_BITS_START};
        else
            rc_set = 1'b0;
    end

    // Return code and its change pulse
    always_ff @(posedge clock_in)
    begin
        if (clr)
        begin
            rec <= `SBRX_REC_RESET;
            rc_changed_out <= 1'b0;
        end
        else
        begin
            if (rc_set)
                rec <= rc_val;
            rc_changed_out <= rc_set;
        end
    end

    // Byte counts latched when the frame ends
    always_ff @(posedge clock_in)
    begin
        if (clr)
        begin
            master_cnt <= `SBRX_CNT_RESET;
            slave_cnt <= `SBRX_CNT_RESET;
        end
        else if (link_end_in && st != SBRX_ST_IDLE && !mcast_err)
        begin
            if (kind == SBRX_KIND_MASTER)
                master_cnt <= next_byte_cnt;
            else
                slave_cnt <= next_byte_cnt;
        end
    end

    // Source of a failed multicast, overwritten by each new reported error
    always_ff @(posedge clock_in)
    begin
        if (clr)
        begin
            src_low <= `SBRX_REG_RESET;
            src_high <= `SBRX_REG_RESET;
        end
        else if (mcast_err)
        begin
            src_high <= link_mcast_src_in[11:4];
            src_low <= {link_mcast_src_in[3:0], 4'h0};
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in || !cpu_rd_in)
            cpu_rdata_out <= `SBRX_READ_ZERO;
        else
        begin
            case (cpu_addr_in)
                `SBRX_ADDR_RC:
                    cpu_rdata_out <= {1'b0, `SBRX_RC_TX_RESET, rec};
                `SBRX_ADDR_CMD:
                    cpu_rdata_out <= {6'h00, report_en, 1'b0};
                `SBRX_ADDR_RBF:
                    cpu_rdata_out <= fifo_out_valid ? fifo_out_data
                        : `SBRX_READ_ZERO;
                `SBRX_ADDR_MCNT:
                    cpu_rdata_out <= master_cnt;
                `SBRX_ADDR_SCNT:
                    cpu_rdata_out <= slave_cnt;
                `SBRX_ADDR_SRC_LOW:
                    cpu_rdata_out <= src_low;
                `SBRX_ADDR_SRC_HIGH:
                    cpu_rdata_out <= src_high;
                default:
                    cpu_rdata_out <= `SBRX_READ_ZERO;
            endcase
        end
    end
endmodule : sbrx_rx_status

// ---- bench/sbrx_link_model.sv ----
// Far-side bus unit model that hands received frames to the block.
`timescale 1ns/1ns
module sbrx_link_model (
    input wire logic clock_in,
    input wire logic link_byte_ready_out,
    output logic link_start_in,
    output sbrx_pkg::sbrx_kind_e link_kind_in,
    output logic link_byte_valid_in,
    output logic [7:0] link_byte_in,
    output logic link_end_in,
    output logic link_complete_in,
    output logic link_mcast_err_in,
    output logic [11:0] link_mcast_src_in
);
    import sbrx_pkg::*;

    // Idle lines start low
    initial
    begin
        link_start_in = 1'b0;
        link_kind_in = SBRX_KIND_MASTER;
        link_byte_valid_in = 1'b0;
        link_byte_in = 8'h00;
        link_end_in = 1'b0;
        link_complete_in = 1'b0;
        link_mcast_err_in = 1'b0;
        link_mcast_src_in = 12'h000;
    end

    // Frame opens with a one-cycle start pulse
    task automatic start(input sbrx_kind_e k);
        link_kind_in = k;
        link_start_in = 1'b1;
        @(posedge clock_in);
        #1;
        link_start_in = 1'b0;
        @(posedge clock_in);
        #1;
    endtask : start

    // Byte held until taken; bounded so a stuck ready cannot hang us
    task automatic put(input logic [7:0] v);
        int n;
        n = 0;
        link_byte_valid_in = 1'b1;
        link_byte_in = v;
        @(posedge clock_in);
        while (!link_byte_ready_out && n < 64)
        begin
            n++;
            @(posedge clock_in);
        end
        #1;
        link_byte_valid_in = 1'b0;
        link_byte_in = ~v; // Released line must not look valid
        @(posedge clock_in);
        #1;
    endtask : put

    // Frame end, full length or cut short
    task automatic stop(input logic c);
        link_complete_in = c;
        link_end_in = 1'b1;
        @(posedge clock_in);
        #1;
        link_end_in = 1'b0;
        link_complete_in = ~c;
        @(posedge clock_in);
        #1;
    endtask : stop

    // Multicast error with the sending master's address
    task automatic err(input logic [11:0] s);
        link_mcast_src_in = s;
        link_mcast_err_in = 1'b1;
        @(posedge clock_in);
        #1;
        link_mcast_err_in = 1'b0;
        link_mcast_src_in = ~s;
        @(posedge clock_in);
        #1;
    endtask : err
endmodule : sbrx_link_model

// ---- bench/sbrx_rx_status_asserts.sv ----
// Port-level concurrent checks for the reception status block.
`timescale 1ns/1ns
`include "sbrx_defines.svh"
module sbrx_rx_status_asserts (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [`SBRX_ADDR_W-1:0] cpu_addr_in,
    input wire logic cpu_wr_in,
    input wire logic cpu_rd_in,
    input wire logic [7:0] cpu_wdata_in,
    input wire logic [7:0] cpu_rdata_out,
    input wire logic link_start_in,
    input wire logic link_byte_valid_in,
    input wire logic link_end_in,
    input wire logic link_mcast_err_in,
    input wire logic link_byte_ready_out,
    input wire logic link_nak_out,
    input wire logic [11:0] own_addr_out,
    input wire logic [1:0] tx_mode_out,
    input wire logic slave_tx_enable_out,
    input wire logic rc_changed_out
);
    logic rep_en;
    logic rd_rc;
    logic quiet;

    // Shadow of the error report enable, mirrors command writes
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
            rep_en <= 1'b0;
        else if (cpu_wr_in && cpu_addr_in == `SBRX_ADDR_CMD)
            rep_en <= cpu_wdata_in[`SBRX_CMD_OPTION_ERROR_REPORT_ENABLE_BIT];
    end

    // Return code read strobe, and other events that could move the code in the same cycle
    assign rd_rc = cpu_rd_in && cpu_addr_in == `SBRX_ADDR_RC;
    assign quiet = !link_start_in && !link_end_in && !link_byte_valid_in
        && !cpu_wr_in;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    AST_RC_TOP: assert property (rd_rc |=> cpu_rdata_out[7:4] == 4'h4)
        else $error("return code upper nibble wrong");
    AST_RC_RSVD: assert property (rd_rc |=>
        !(cpu_rdata_out[3:0] inside {4'hd, 4'he}))
        else $error("reserved return code seen");
    AST_UAR_HIGH: assert property (
        cpu_wr_in && cpu_addr_in == `SBRX_ADDR_UAR_HIGH
        |=> own_addr_out[11:4] == $past(cpu_wdata_in))
        else $error("own address high byte not taken");
    AST_UAR_LOW: assert property (
        cpu_wr_in && cpu_addr_in == `SBRX_ADDR_UAR_LOW
        |=> {own_addr_out[3:0], slave_tx_enable_out, tx_mode_out}
        == {$past(cpu_wdata_in[7:4]), $past(cpu_wdata_in[2:0])})
        else $error("own address low register not taken");
    AST_START_CODE: assert property (link_start_in |=> rc_changed_out)
        else $error("no code update after frame start");
    AST_END_IDLE: assert property (link_end_in |=> !link_byte_ready_out)
        else $error("bytes accepted after frame end");
    AST_NAK_END: assert property (link_end_in |=> !link_nak_out)
        else $error("refusal outlives the frame");
    AST_NAK_FULL: assert property ($rose(link_nak_out)
        |-> !link_byte_ready_out && !$past(link_byte_ready_out))
        else $error("refusal while buffer had room");
    AST_ERR_GATED: assert property (
        link_mcast_err_in && !rep_en && quiet |=> !rc_changed_out)
        else $error("error code while reporting off");
    AST_ERR_CODE: assert property (
        link_mcast_err_in && rep_en |=> rc_changed_out)
        else $error("no error code while reporting on");

    // Main scenarios reached
    COV_START: cover property (link_start_in);
    COV_NAK: cover property ($rose(link_nak_out));
    COV_ERR: cover property (link_mcast_err_in && rep_en);
endmodule : sbrx_rx_status_asserts

bind sbrx_rx_status sbrx_rx_status_asserts u_sbrx_rx_status_asserts (.*);

// ---- bench/sbrx_rx_status_tb.sv ----
// Self-checking bench for the reception status block.
`timescale 1ns/1ns
`include "sbrx_defines.svh"
module sbrx_rx_status_tb;
    import sbrx_pkg::*;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [15:0] cpu_addr_in;
    logic cpu_wr_in = 1'b0;
    logic cpu_rd_in = 1'b0;
    logic [7:0] cpu_wdata_in;
    logic [7:0] cpu_rdata_out;
    logic link_start_in, link_byte_valid_in, link_end_in;
    logic link_complete_in, link_mcast_err_in;
    sbrx_kind_e link_kind_in;
    logic [7:0] link_byte_in;
    logic [11:0] link_mcast_src_in, own_addr_out;
    logic link_byte_ready_out, link_nak_out, slave_tx_enable_out;
    logic rc_changed_out;
    logic [1:0] tx_mode_out;
    logic [7:0] bs;
    int nd;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;

    // Short limits keep the late-read case quick; mode 2 waits 10
    sbrx_rx_status #(.LIMIT_M0_CYC(40), .LIMIT_M1_CYC(20),
        .LIMIT_M2_CYC(10)) u_sbrx_rx_status (.*);

    sbrx_link_model u_m (.*);

    always #2 clock_in = ~clock_in;

    task automatic give_verdict();
        if (err_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Strobe for one edge, then a spare edge so strobes never abut
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cpu_addr_in = a;
        cpu_wdata_in = d;
        cpu_wr_in = 1'b1;
        @(posedge clock_in);
        #1;
        cpu_wr_in = 1'b0;
        @(posedge clock_in);
        #1;
    endtask : wr

    // Read data stands only in the cycle after the strobe edge
    task automatic chk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        cpu_addr_in = a;
        cpu_rd_in = 1'b1;
        @(posedge clock_in);
        #1;
        cpu_rd_in = 1'b0;
        d = cpu_rdata_out;
        cmp({4'h0, d}, {4'h0, e});
        @(posedge clock_in);
        #1;
    endtask : chk

    // Pops n bytes from b upward, then one empty read
    task automatic drain(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++)
            chk(`SBRX_ADDR_RBF, b + 8'(i));
        chk(`SBRX_ADDR_RBF, 8'h00);
    endtask : drain

    // Hang guard, far above the run's length
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (3) @(posedge clock_in);
        #1;
        rst_b_in = 1'b1;
        chk(`SBRX_ADDR_RC, 8'h4f);
        chk(`SBRX_ADDR_MCNT, 8'h00);
        chk(`SBRX_ADDR_SCNT, 8'h00);
        chk(16'hf8f3, 8'h00);
        wr(`SBRX_ADDR_CMD, 8'h01);
        wr(`SBRX_ADDR_UAR_HIGH, 8'ha5);
        wr(`SBRX_ADDR_UAR_LOW, 8'h96);
        cmp(own_addr_out, 12'ha59);
        cmp(12'({slave_tx_enable_out, tx_mode_out}), 12'h006);
        // Every kind, full length and cut short
        for (int k = 0; k < 3; k++)
        begin
            for (int c = 0; c < 2; c++)
            begin
                bs = 8'(32 * k + 16 * c);
                nd = 1 + k + c;
                u_m.start(sbrx_kind_e'(k));
                chk(`SBRX_ADDR_RC, {4'h4, 2'(k), 2'h0});
                for (int i = 0; i < nd + 3; i++)
                    u_m.put(bs + 8'(i));
                u_m.stop(c[0]);
                chk(`SBRX_ADDR_RC, {4'h4, 2'(k), 1'b1, ~c[0]});
                chk(k == 0 ? `SBRX_ADDR_MCNT : `SBRX_ADDR_SCNT, 8'(nd));
                drain(nd + 3, bs);
            end
        end
        // Buffer filled; slave frame read in time, others left late
        for (int k = 0; k < 3; k++)
        begin
            u_m.start(sbrx_kind_e'(k));
            for (int i = 0; i < 16; i++)
                u_m.put(8'(i));
            chk(`SBRX_ADDR_RC, {4'h4, 2'(k), 2'h1});
            if (k == 1)
                chk(`SBRX_ADDR_RBF, 8'h00);
            repeat (12) @(posedge clock_in);
            #1;
            cmp(12'(link_nak_out), 12'(k != 1));
            u_m.stop(1'b0);
            cmp(12'(link_nak_out), 12'h000);
            chk(k == 0 ? `SBRX_ADDR_MCNT : `SBRX_ADDR_SCNT, 8'h0d);
            drain(k == 1 ? 15 : 16, 8'(k == 1));
        end
        // Multicast error, first unreported then reported
        u_m.start(SBRX_KIND_MULTI);
        u_m.err(12'h3c7);
        chk(`SBRX_ADDR_RC, 8'h48);
        wr(`SBRX_ADDR_CMD, 8'h02);
        u_m.err(12'h3c7);
        chk(`SBRX_ADDR_RC, 8'h4c);
        chk(`SBRX_ADDR_SRC_HIGH, 8'h3c);
        chk(`SBRX_ADDR_SRC_LOW, 8'h70);
        // Soft reset in mid-run
        wr(`SBRX_ADDR_CMD, 8'h01);
        chk(`SBRX_ADDR_RC, 8'h4f);
        chk(`SBRX_ADDR_SCNT, 8'h00);
        chk(`SBRX_ADDR_MCNT, 8'h00);
        cmp(own_addr_out, 12'h000);
        give_verdict();
    end
endmodule : sbrx_rx_status_tb
